// [shared/uarx_pkg.sv]
// uarx_pkg: shared constants for the uart receive path with status fifo
package uarx_pkg;
  // register byte offsets
  localparam logic [11:0] UARX_OFF_DATA = 12'h0_050; // received data word
  localparam logic [11:0] UARX_OFF_CTRL = 12'h0_060; // receive control
  localparam logic [11:0] UARX_OFF_LCR = 12'h0_064; // line control high
  localparam logic [11:0] UARX_OFF_BAUD = 12'h0_068; // baud divisor
  localparam logic [11:0] UARX_OFF_STAT = 12'h0_070; // uart_status_flags
  localparam logic [11:0] UARX_OFF_IRQ_STAT = 12'h0_080; // sticky events
  localparam logic [11:0] UARX_OFF_IRQ_EN = 12'h0_084; // event enables
  localparam logic [11:0] UARX_OFF_IRQ_CLR = 12'h0_088; // write one to clear
  // status register fields
  localparam int UARX_ST_FRAMING_ERROR_FLAG = 16; // framing_error_flag
  localparam int UARX_ST_PARITY_ERROR_FLAG = 17; // parity_error_flag
  localparam int UARX_ST_BREAK_ERROR_FLAG = 18; // break_error_flag
  localparam int UARX_ST_OERR = 19; // overrun flag
  localparam int UARX_ST_RX_FIFO_EMPTY_FLAG = 24; // rx_fifo_empty_flag
  localparam int UARX_ST_TX_FIFO_FULL_FLAG = 25; // tx_fifo_full_flag
  localparam int UARX_ST_RX_FIFO_FULL_FLAG = 26; // rx_fifo_full_flag
  localparam int UARX_ST_TX_FIFO_EMPTY_FLAG = 27; // tx_fifo_empty_flag
  localparam int UARX_ST_CNT_LSB = 0; // receive fill count
  // control fields
  localparam int UARX_CTRL_EN = 0; // receiver enable
  localparam int UARX_LCR_PEN = 1; // parity enable
  localparam int UARX_LCR_EPS = 2; // even parity select
  localparam int UARX_LCR_FEN = 4; // fifo enable
  localparam int UARX_LCR_WLEN = 5; // word length, 2 bits
  localparam int UARX_LCR_SPS = 7; // stick parity
  // reset values
  localparam logic [31:0] UARX_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] UARX_LCR_RST = 32'h0000_0000;
  localparam logic [15:0] UARX_BAUD_RST = 16'h0000_0010; // 16 clocks per oversample tick
  // entry layout: status in bits 11:8, byte in 7:0
  localparam int UARX_ENT_W = 12;
  localparam int UARX_ENT_FRAMING_ERROR_FLAG = 8;
  localparam int UARX_ENT_PARITY_ERROR_FLAG = 9;
  localparam int UARX_ENT_BREAK_ERROR_FLAG = 10;
  localparam int UARX_ENT_OERR = 11;
  // interrupt event bits
  localparam int UARX_EV_RX = 0;
  localparam int UARX_EV_ERR = 1;
  localparam int UARX_EV_BRK = 2;
  localparam int UARX_EV_OVR = 3;
  localparam int UARX_EV_N = 4;
  // oversampling rate
  localparam logic [3:0] UARX_OVS_LAST = 4'h0_f;
  localparam logic [3:0] UARX_OVS_MID = 4'h0_7;
endpackage : uarx_pkg

// [hw/uarx_deser.sv]
// uarx_deser: bit-level receiver with break detection
`timescale 1ns/1ps
module uarx_deser
  import uarx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic enable, // receiver on
  input wire logic rxd_s, // synchronised line
  input wire logic [15:0] baud_div, // clocks per oversample tick
  input wire logic [1:0] wlen, // 5..8 data bits
  input wire logic par_en,
  input wire logic par_even,
  input wire logic par_stick,
  output logic char_vld, // one-cycle pulse
  output logic [UARX_ENT_W-2:0] char_word // break_error_flag,parity_error_flag,framing_error_flag,data
);
  typedef enum logic [2:0] {UARX_IDLE, UARX_START, UARX_DATA, UARX_PAR, UARX_STOP,
                            UARX_BRKWAIT} uarx_st_t;
  uarx_st_t st_q;
  logic [15:0] div_q; // clock divider
  logic tick; // oversample tick
  logic [3:0] ovs_q; // ticks within a bit
  logic [2:0] bit_q; // data bit index
  logic [7:0] sh_q; // data shift
  logic par_q; // running xor
  logic parity_error_flag_q; // parity mismatch
  logic allz_q; // every sampled bit low so far
  logic [2:0] last_bit;
  logic samp; // mid-bit sample point
  logic exp_par; // parity the line should carry

  assign tick = (div_q == 16'h0_000);
  assign samp = tick && (ovs_q == UARX_OVS_MID);
  assign last_bit = {1'b1, wlen};
  // stick parity: even sel gives 0, odd gives 1
  assign exp_par = par_stick ? ~par_even : (par_even ? par_q : ~par_q);

  // oversample divider
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 16'h0_000;
    end else if (tick || st_q == UARX_IDLE) begin
      div_q <= baud_div - 16'h0_001;
    end else begin
      div_q <= div_q - 16'h0_001;
    end
  end

  // frame sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= UARX_IDLE;
      ovs_q <= 4'h0_0;
      bit_q <= 3'h0;
      sh_q <= 8'h0_0;
      par_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      allz_q <= 1'b0;
      char_vld <= 1'b0;
      char_word <= '0;
    end else begin
      char_vld <= 1'b0;
      if (tick && st_q != UARX_IDLE) ovs_q <= ovs_q + 4'h0_1;
      case (st_q)
        UARX_IDLE: begin
          ovs_q <= 4'h0_0;
          if (enable && !rxd_s) st_q <= UARX_START; // new start bit
        end
        UARX_START: if (samp) begin
          ovs_q <= 4'h0_8;
          bit_q <= 3'h0;
          par_q <= 1'b0;
          allz_q <= 1'b1;
          sh_q <= 8'h0_0;
          st_q <= rxd_s ? UARX_IDLE : UARX_DATA; // false start rejected
        end
        UARX_DATA: if (samp) begin
          ovs_q <= 4'h0_8;
          sh_q[bit_q] <= rxd_s;
          par_q <= par_q ^ rxd_s;
          allz_q <= allz_q & ~rxd_s;
          bit_q <= bit_q + 3'h1;
          if (bit_q == last_bit) st_q <= par_en ? UARX_PAR : UARX_STOP;
        end
        UARX_PAR: if (samp) begin
          ovs_q <= 4'h0_8;
          parity_error_flag_q <= (rxd_s != exp_par);
          allz_q <= allz_q & ~rxd_s;
          st_q <= UARX_STOP;
        end
        UARX_STOP: if (samp) begin
          char_vld <= 1'b1;
          // low through start, data, parity and stop: a break
          if (allz_q && !rxd_s) begin
            char_word <= {1'b1, 1'b0, 1'b0, 8'h0_0};
            st_q <= UARX_BRKWAIT;
          end else begin
            char_word <= {1'b0, parity_error_flag_q & par_en, ~rxd_s, sh_q};
            st_q <= rxd_s ? UARX_IDLE : UARX_BRKWAIT;
          end
          parity_error_flag_q <= 1'b0;
        end
        UARX_BRKWAIT: begin
          // hold off until line returns to marking
          if (rxd_s) st_q <= UARX_IDLE;
        end
        default: st_q <= UARX_IDLE;
      endcase
    end
  end
endmodule : uarx_deser

// [hw/uarx_store.sv]
// uarx_store: receive fifo of status-tagged characters
`timescale 1ns/1ps
module uarx_store
  import uarx_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fifo_on, // off: single holding register
  input wire logic push,
  input wire logic [UARX_ENT_W-1:0] push_word,
  input wire logic pop,
  output logic [UARX_ENT_W-1:0] top_word, // oldest entry
  output logic empty,
  output logic full,
  output logic [AW:0] count
);
  logic [UARX_ENT_W-1:0] mem_q [DEPTH]; // storage
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign empty = (cnt_q == '0);
  // holding mode: one entry makes it full
  assign full = fifo_on ? (cnt_q == (AW+1)'(DEPTH)) : (cnt_q != '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign top_word = mem_q[rd_q];
  assign count = cnt_q;

  // entry write
  always_ff @(posedge mclk) begin
    if (do_push) mem_q[wr_q] <= push_word;
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      // a refused char is dropped, a pop in that cycle still counts
      if (do_push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      if (do_pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : uarx_store

// [hw/uarx_top.sv]
// uarx_top: uart receive path, ahb-lite register slave
// Behaviour
// - fifo on: push byte plus four status bits
// - fifo off: single holding register, entry at the write pointer
// - data read returns up to four bytes
// - overrun set on full, cleared when stored
// - break: low longer than one character
// - break loads exactly one zero character
// - after break wait marking then start
// - parity error per line control bits two, seven
// - framing error when stop bit not one
// - errors travel with each character through the fifo
// - status flags merge the chars of the last data read
// - overrun shows in status immediately
// - status register at 0x070 with fifo flags
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module uarx_top
  import uarx_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd, // serial receive pin
  output logic irq // level interrupt
);
  // pin synchroniser
  // the serial pin is asynchronous to mclk
  logic rxd_m_q; // first stage, read only by second
  logic rxd_s_q; // second stage

  // registers
  // ctrl, lcr and baud reset to the package values, the rest to zero
  logic [31:0] ctrl_q; // receive control
  logic [31:0] lcr_q; // line_control_high
  logic [15:0] baud_q; // clocks per oversample tick
  logic [3:0] last_err_q; // merged status of chars in last data read
  logic ovr_q; // live overrun flag
  logic [UARX_EV_N-1:0] ev_q; // sticky events
  logic [UARX_EV_N-1:0] ev_en_q; // event enables
  logic [UARX_EV_N-1:0] ev_set; // events raised this cycle
  logic [UARX_EV_N-1:0] ev_clr; // bits written one to clear

  // bus address phase capture
  logic ap_wr_q; // write waiting for its data phase
  logic [11:0] ap_addr_q;
  logic ap_take;

  // read sequencer for multi-byte data reads
  // idle waits for a data read, pop takes an entry a cycle
  // done answers the bus and latches the status errors
  typedef enum logic [1:0] {UARX_BUS_IDLE, UARX_BUS_POP, UARX_BUS_DONE} uarx_bus_t;
  uarx_bus_t bus_q;
  logic [31:0] acc_q; // gathered bytes
  logic [1:0] nb_q; // bytes gathered
  logic [3:0] acc_err_q; // or of gathered status

  // deserialiser and store
  // char_word: break, parity, framing, then the byte
  // top_word: oldest entry with its four status bits
  logic char_vld;
  logic [UARX_ENT_W-2:0] char_word;
  logic [UARX_ENT_W-1:0] top_word;
  logic st_empty;
  logic st_full;
  logic [AW:0] st_count;
  logic st_pop;
  logic [31:0] stat_word;

  // two flops before any logic sees the pin
  // reset to marking, so no false start follows reset
  // only the second stage reads the first
  // two clocks of delay per edge, well inside a bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // bit receiver: start, data, parity, stop, break
  // baud divisor: clocks per tick, sixteen ticks a bit
  // a char leaves as a pulse mid stop bit
  uarx_deser u_deser (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(ctrl_q[UARX_CTRL_EN]),
    .rxd_s(rxd_s_q),
    .baud_div(baud_q),
    .wlen(lcr_q[UARX_LCR_WLEN+1:UARX_LCR_WLEN]),
    .par_en(lcr_q[UARX_LCR_PEN]),
    .par_even(lcr_q[UARX_LCR_EPS]),
    .par_stick(lcr_q[UARX_LCR_SPS]),
    .char_vld(char_vld),
    .char_word(char_word)
  );

  // receive storage; fifo bit off: one holding entry
  // each entry keeps the overrun flag from before it
  // a char that finds the store full is dropped
  uarx_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
    .mclk(mclk),
    .rst_b(rst_b),
    .fifo_on(lcr_q[UARX_LCR_FEN]),
    .push(char_vld),
    .push_word({ovr_q, char_word}),
    .pop(st_pop),
    .top_word(top_word),
    .empty(st_empty),
    .full(st_full),
    .count(st_count)
  );

  // taken on nonseq or seq with hready high
  assign ap_take = hsel && hready && htrans[1];
  // one entry leaves a cycle while a read gathers
  assign st_pop = (bus_q == UARX_BUS_POP) && !st_empty;

  // status word: fifo flags, latched char errors, live overrun
  // fill count in the low bits, fifo flags near the top
  // transmit flags fixed, there is no transmit path
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[UARX_ST_FRAMING_ERROR_FLAG] = last_err_q[0];
    stat_word[UARX_ST_PARITY_ERROR_FLAG] = last_err_q[1];
    stat_word[UARX_ST_BREAK_ERROR_FLAG] = last_err_q[2];
    stat_word[UARX_ST_OERR] = ovr_q;
    stat_word[UARX_ST_RX_FIFO_EMPTY_FLAG] = st_empty;
    stat_word[UARX_ST_RX_FIFO_FULL_FLAG] = st_full;
    stat_word[UARX_ST_TX_FIFO_EMPTY_FLAG] = 1'b1; // no transmit path here
    stat_word[UARX_ST_TX_FIFO_FULL_FLAG] = 1'b0;
    stat_word[UARX_ST_CNT_LSB +: AW+1] = st_count;
  end

  // overrun: set on full arrival, cleared once a char is stored
  // the refused char is lost, only the flag tells
  // a data read alone leaves it set
  // holding mode: an unread char alone means full
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ovr_q <= 1'b0;
    end else if (char_vld) begin
      ovr_q <= st_full;
    end
  end

  // address phase capture
  // writes land one edge later, with hwdata standing
  // frozen while hreadyout is low, nothing is taken then
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 12'h0_000;
    end else if (hreadyout) begin
      ap_wr_q <= ap_take && hwrite;
      ap_addr_q <= haddr[11:0];
    end
  end

  // data-register read: pop up to four entries, one per cycle
  // the bus waits here until the bytes are in
  // oldest byte in the low lane; empty ends it early
  // errors of all popped chars are merged for status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_q <= UARX_BUS_IDLE;
      acc_q <= 32'h0000_0000;
      nb_q <= 2'h0;
      acc_err_q <= 4'h0;
      last_err_q <= 4'h0;
    end else begin
      case (bus_q)
        UARX_BUS_IDLE: begin
          // a data read address phase starts a gather
          if (ap_take && !hwrite && haddr[11:0] == UARX_OFF_DATA) begin
            bus_q <= UARX_BUS_POP;
            acc_q <= 32'h0000_0000;
            nb_q <= 2'h0;
            acc_err_q <= 4'h0;
          end
        end
        UARX_BUS_POP: begin
          if (st_empty) begin
            // nothing left: answer with what is gathered
            bus_q <= UARX_BUS_DONE;
          end else begin
            // oldest entry into the next byte lane
            acc_q[{nb_q, 3'b000} +: 8] <= top_word[7:0];
            acc_err_q <= acc_err_q | top_word[11:8];
            nb_q <= nb_q + 2'h1;
            if (nb_q == 2'h3) bus_q <= UARX_BUS_DONE;
          end
        end
        UARX_BUS_DONE: begin
          // status now describes the chars just read
          last_err_q <= acc_err_q;
          bus_q <= UARX_BUS_IDLE;
        end
        default: bus_q <= UARX_BUS_IDLE;
      endcase
    end
  end

  // register writes
  // address from the capture, data from the data phase
  // a zero divisor would stall the receiver: one instead
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= UARX_CTRL_RST;
      lcr_q <= UARX_LCR_RST;
      baud_q <= UARX_BAUD_RST;
      ev_en_q <= '0;
    end else if (ap_wr_q) begin
      case (ap_addr_q)
        UARX_OFF_CTRL: ctrl_q <= hwdata;
        // line control takes effect at once, even mid char
        UARX_OFF_LCR: lcr_q <= hwdata;
        UARX_OFF_BAUD: baud_q <= (hwdata[15:0] == 16'h0_000) ? 16'h0_001 : hwdata[15:0];
        UARX_OFF_IRQ_EN: ev_en_q <= hwdata[UARX_EV_N-1:0];
        default: ;
      endcase
    end
  end

  // event strobes and the write-one-to-clear mask
  // event and clear in one cycle: the event wins
  always_comb begin
    ev_set = '0;
    ev_set[UARX_EV_RX] = char_vld;
    ev_set[UARX_EV_ERR] = char_vld && (char_word[9:8] != 2'b00); // parity or framing
    ev_set[UARX_EV_BRK] = char_vld && char_word[10];
    ev_set[UARX_EV_OVR] = char_vld && st_full;
    ev_clr = '0;
    if (ap_wr_q && ap_addr_q == UARX_OFF_IRQ_CLR) begin
      ev_clr = hwdata[UARX_EV_N-1:0]; // ones clear
    end
  end

  // sticky events; set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  // irq level from flop
  // one cycle behind status and enables
  // stays high until the event is cleared or masked
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_q & ev_en_q);
    end
  end

  // read data, ready and response
  // register reads: no wait, hrdata set at address edge
  // a data read holds hreadyout low until gathered
  // hresp stays okay; unmapped writes are dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (ap_take && !hwrite && haddr[11:0] == UARX_OFF_DATA && bus_q == UARX_BUS_IDLE) begin
        hreadyout <= 1'b0; // wait while bytes are gathered
      end else if (bus_q == UARX_BUS_DONE) begin
        // gather done: release the bus with the word
        hreadyout <= 1'b1;
        hrdata <= acc_q;
      end else if (ap_take && !hwrite) begin
        // plain register read, answered at once
        hreadyout <= 1'b1;
        case (haddr[11:0])
          UARX_OFF_STAT: hrdata <= stat_word;
          UARX_OFF_CTRL: hrdata <= ctrl_q;
          UARX_OFF_LCR: hrdata <= lcr_q;
          UARX_OFF_BAUD: hrdata <= {16'h0_000, baud_q};
          UARX_OFF_IRQ_STAT: hrdata <= {{(32-UARX_EV_N){1'b0}}, ev_q};
          UARX_OFF_IRQ_EN: hrdata <= {{(32-UARX_EV_N){1'b0}}, ev_en_q};
          // unmapped offsets read zero
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : uarx_top

// [tb/uarx_top_properties.sv]
// uarx_top_properties: port-level checks of the receive path slave
`timescale 1ns/1ps
module uarx_top_properties
  import uarx_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd,
  input wire logic irq
);
  wire logic tk = hsel && hready && htrans[1]; // transfer taken
  wire logic rd = tk && !hwrite; // read taken
  wire logic rd_dat = rd && haddr[11:0] == UARX_OFF_DATA; // data word read
  wire logic rd_st = rd && haddr[11:0] == UARX_OFF_STAT; // status read
  logic en_wr_q; // data phase of an enable write
  // remember enable writes until their data phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_wr_q <= 1'b0;
    end else begin
      en_wr_q <= tk && hwrite && haddr[11:0] == UARX_OFF_IRQ_EN;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_st_tx;
    rd_st |=> !hrdata[UARX_ST_TX_FIFO_FULL_FLAG] && hrdata[UARX_ST_TX_FIFO_EMPTY_FLAG];
  endproperty
  a_st_tx: assert property (p_st_tx) else $error("tx flags wrong");
  property p_st_fill;
    rd_st |=> (hrdata[UARX_ST_RX_FIFO_EMPTY_FLAG] == (hrdata[AW:0] == '0))
      && (!hrdata[UARX_ST_RX_FIFO_FULL_FLAG] || hrdata[AW:0] != '0);
  endproperty
  a_st_fill: assert property (p_st_fill) else $error("empty flag vs count");
  property p_st_excl;
    rd_st |=> !(hrdata[UARX_ST_RX_FIFO_EMPTY_FLAG] && hrdata[UARX_ST_RX_FIFO_FULL_FLAG]);
  endproperty
  a_st_excl: assert property (p_st_excl) else $error("empty and full");
  property p_unmapped;
    rd && haddr[11:0] == 12'h0fc |=> hrdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dat_wait;
    rd_dat |=> !hreadyout;
  endproperty
  a_dat_wait: assert property (p_dat_wait) else $error("data read no wait");
  property p_dat_bound;
    $fell(hreadyout) |-> ##[1:6] hreadyout;
  endproperty
  a_dat_bound: assert property (p_dat_bound) else $error("data read too long");
  property p_wait_cause;
    $fell(hreadyout) |-> $past(rd_dat);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait without data read");
  property p_other_ready;
    rd && !rd_dat |=> hreadyout;
  endproperty
  a_other_ready: assert property (p_other_ready) else $error("register read waited");
  property p_wr_hold;
    tk && hwrite |=> $stable(hrdata);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("read data moved on write");
  property p_irq_off;
    en_wr_q && hwdata == 32'h0000_0000 |-> ##[1:3] !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
  property p_okay;
    tk |=> !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
endmodule : uarx_top_properties

bind uarx_top uarx_top_properties #(.DEPTH(DEPTH), .AW(AW)) uarx_top_properties_i (
  .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .rxd(rxd), .irq(irq));

// [tb/uarx_tx_model.sv]
// uarx_tx_model: remote serial transmitter driving the receive line
`timescale 1ns/1ps
module uarx_tx_model #(
  parameter int BIT = 16
)(
  input wire logic mclk,
  output logic rxd
);
  // line marks high while idle
  initial begin
    rxd = 1'b1;
  end
  // drive one level for n clocks, changed just after an edge
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge mclk);
  endtask : hold
  // frame: start, eight data bits lsb first, parity if par >= 0, stop
  task automatic send(input logic [7:0] b, input int par, input logic stp);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], BIT);
    end
    if (par >= 0) begin
      hold(par[0], BIT);
    end
    hold(stp, BIT);
    hold(1'b1, 2 * BIT); // back to marking
  endtask : send
endmodule : uarx_tx_model

// [tb/uarx_top_bench.sv]
// uarx_top_bench: self-checking bench of the receive path with a store model
`timescale 1ns/1ps
module uarx_top_bench
  import uarx_pkg::*;
();
  logic mclk, rst_b, hsel, hwrite, hreadyout, hresp, rxd, irq;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] b;
  wire logic hready = hreadyout; // single slave
  int errors, n_compared, ovr, lerr, dep;
  int q[$]; // model store: err bits 10:8, byte 7:0
  always #12.5 mclk = ~mclk;
  uarx_top #(.DEPTH(4), .AW(2)) uarx_top_i (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
    .irq(irq));
  uarx_tx_model #(.BIT(16)) uarx_tx_model_i (.mclk(mclk), .rxd(rxd));
  // xorshift byte source
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs
  // expected status word
  function automatic logic [31:0] stat();
    int n;
    n = q.size();
    return 32'(n) | (32'(n == 0) << 24) | (32'(n >= dep) << 26) | (32'h1 << 27)
      | (32'(ovr) << 19) | (32'(lerr) << 16);
  endfunction : stat
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t value got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bounded wait for hready high at an edge
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      errors++;
      $display("MISMATCH %0t bus timeout", $time);
      conclude();
    end
  endtask : rdy
  // one single ahb-lite transfer
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy();
    r = hrdata;
  endtask : ahb
  // modelled arrival: overrun when full
  task automatic chr(input logic [7:0] c, input int par, input logic stp, input int e);
    uarx_tx_model_i.send(c, par, stp);
    if (q.size() >= dep) begin
      ovr = 1;
    end else begin
      q.push_back(e | c);
      ovr = 0;
    end
  endtask : chr
  task automatic cst();
    ahb(1'b0, UARX_OFF_STAT, '0);
    chk(r, stat());
  endtask : cst
  // data word read: oldest byte lowest, errors of popped chars
  task automatic cdt();
    logic [31:0] e;
    int k;
    e = '0;
    k = 0;
    lerr = 0;
    while (k < 4 && q.size() > 0) begin
      e = e | (32'(q[0] & 255) << (8 * k));
      lerr = lerr | ((q[0] >> 8) & 7);
      void'(q.pop_front());
      k++;
    end
    ahb(1'b0, UARX_OFF_DATA, '0);
    chk(r, e);
  endtask : cdt
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    errors = 0;
    n_compared = 0;
    ovr = 0;
    lerr = 0;
    dep = 1;
    seed = 32'h0000_a3bb;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    cst();
    ahb(1'b0, UARX_OFF_BAUD, '0);
    chk(r, 32'(UARX_BAUD_RST));
    ahb(1'b0, 12'h0fc, '0);
    chk(r, 32'h0000_0000);
    $display("test reset done");
    // holding register: second char overruns
    ahb(1'b1, UARX_OFF_BAUD, 32'h0000_0001);
    ahb(1'b1, UARX_OFF_CTRL, 32'h0000_0001);
    ahb(1'b1, UARX_OFF_LCR, 32'h0000_0060);
    chr(xs(), -1, 1'b1, 0);
    chr(xs(), -1, 1'b1, 0);
    cst();
    cdt();
    chr(xs(), -1, 1'b1, 0);
    cst();
    cdt();
    $display("test holding done");
    // fifo: fill past full, drain
    ahb(1'b1, UARX_OFF_LCR, 32'h0000_0070);
    dep = 4;
    repeat (5) chr(xs(), -1, 1'b1, 0);
    cst();
    cdt();
    cst();
    chr(xs(), -1, 1'b1, 0);
    cst();
    cdt();
    $display("test fifo done");
    // every parity mode, good then bad
    for (int m = 0; m < 4; m++) begin
      for (int bad = 0; bad < 2; bad++) begin
        b = xs();
        ahb(1'b1, UARX_OFF_LCR, 32'h0000_0072 | (32'(m & 1) << 2) | (32'(m >> 1) << 7));
        chr(b, ((m > 1) ? 0 : int'(^b)) ^ (m & 1) ^ 1 ^ bad, 1'b1, bad << 9);
        cdt();
        cst();
      end
    end
    $display("test parity done");
    // missing stop bit
    ahb(1'b1, UARX_OFF_LCR, 32'h0000_0070);
    chr(xs() | 8'h01, -1, 1'b0, 256);
    cdt();
    cst();
    $display("test framing done");
    // long break, then a normal char
    uarx_tx_model_i.hold(1'b0, 640);
    uarx_tx_model_i.hold(1'b1, 32);
    ahb(1'b0, UARX_OFF_STAT, '0);
    chk(32'(r[2:0]), 32'h0000_0001);
    ahb(1'b0, UARX_OFF_DATA, '0);
    chk(r, 32'h0000_0000);
    ahb(1'b0, UARX_OFF_STAT, '0);
    chk(32'(r[UARX_ST_BREAK_ERROR_FLAG]), 32'h0000_0001);
    chr(xs(), -1, 1'b1, 0);
    cdt();
    cst();
    $display("test break done");
    // interrupt masked, enabled, cleared
    ahb(1'b1, UARX_OFF_IRQ_EN, 32'h0000_0000);
    ahb(1'b1, UARX_OFF_IRQ_CLR, 32'h0000_000f);
    chr(xs(), -1, 1'b1, 0);
    chk(32'(irq), 32'h0000_0000);
    ahb(1'b0, UARX_OFF_IRQ_STAT, '0);
    chk(r, 32'h0000_0001);
    ahb(1'b1, UARX_OFF_IRQ_EN, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0000_0001);
    ahb(1'b1, UARX_OFF_IRQ_CLR, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0000_0000);
    cdt();
    $display("test irq done");
    conclude();
  end
endmodule : uarx_top_bench
